// ==== pkg/mai_pkg.sv ====
// =====================================================================
// Package
// Register map, field layout and carrier types of the interrupt block
package mai_pkg;

  // Number of axes on the card
  localparam int unsigned NUM_AXES = 4;

  // =====================================================================
  // Register map (byte addresses)
  // Each axis owns a block of four words
  localparam logic [7:0] AXIS_STRIDE      = 8'h10;
  localparam logic [7:0] OFS_STOP_CAUSE   = 8'h00; // stop_cause_status
  localparam logic [7:0] OFS_MOTION_PROG  = 8'h04; // motion_progress_status
  localparam logic [7:0] OFS_FACTOR_MASK  = 8'h08; // factor mask
  localparam logic [7:0] OFS_INT_TYPE     = 8'h0c; // interrupt type
  localparam logic [7:0] OFS_SERVICE_CTRL = 8'h40; // service enable
  localparam logic [7:0] OFS_CARD_REQ     = 8'h44; // card request flag
  localparam logic [7:0] AXIS_SPAN        = 8'h40; // axis blocks end

  // =====================================================================
  // Field positions
  localparam int unsigned SVC_FLAG_BIT      = 0;
  localparam int unsigned CARD_REQ_BIT      = 0;
  localparam int unsigned TYPE_STOP_BIT     = 0; // value 0x1
  localparam int unsigned TYPE_PROG_BIT     = 1; // value 0x2
  localparam int unsigned PROG_CNT_LATCH    = 14;

  // Stop cause word bits
  localparam int unsigned STOP_SOFT_POS     = 0;
  localparam int unsigned STOP_SOFT_NEG     = 1;
  localparam int unsigned STOP_GEN_CMP      = 3;
  localparam int unsigned STOP_END_POS      = 5;
  localparam int unsigned STOP_END_NEG      = 6;
  localparam int unsigned STOP_SERVO_ALARM  = 7;
  localparam int unsigned STOP_SYNC_STOP    = 8;
  localparam int unsigned STOP_EMERGENCY    = 9;
  localparam int unsigned STOP_SLOW_DOWN    = 10;
  localparam int unsigned STOP_INTERP_ERR   = 12;
  localparam int unsigned STOP_GROUP_STOP   = 13;
  localparam int unsigned STOP_PULSE_OVF    = 14;
  localparam int unsigned STOP_INTERP_OVF   = 15;
  localparam int unsigned STOP_ENC_ERR      = 16;
  localparam int unsigned STOP_PULSE_ERR    = 17;
  localparam int unsigned STOP_AXIS_STOP    = 31;

  // Implemented bits of each word; reserved bits read as zero
  localparam logic [31:0] STOP_VALID_BITS   = 32'h8003_f7eb;
  localparam logic [31:0] PROG_VALID_BITS   = 32'h0009_d8f7;

  // =====================================================================
  // Reset values
  localparam logic [31:0] RST_STATUS        = 32'h0000_0000;
  localparam logic [31:0] RST_FACTOR_MASK   = 32'h0000_0000;
  localparam logic        RST_SVC_FLAG      = 1'b0;

  // AHB transfer type
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'b10;

  // =====================================================================
  // Carrier: one-cycle event pulses of one axis
  typedef struct packed {
    logic [31:0] stopCause;  // Abnormal stop causes
    logic [31:0] progress;   // Normal motion and comparator events
  } mai_axis_evt_t;

  // Carrier: per-axis interrupt view
  typedef struct packed {
    logic [1:0] intType;     // Pending word indicator
  } mai_axis_view_t;

endpackage : mai_pkg

// ==== design/mai_axis_int.sv ====
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
// Function
// R1 - Interrupt request raised only while the service flag is enabled
// R2 - Each axis keeps separate stop-cause and progress words
// R3 - Progress events request interrupts only where the factor mask is set
// R4 - Stop causes always request when service is enabled, never masked
// R5 - Stop word bit 0 positive, bit 1 negative software limit
// R6 - Stop word bit 3 general comparator stop
// R7 - Stop bits 5,6 end limits, bit 7 servo alarm
// R8 - Stop bit 8 sync stop input, bit 9 emergency stop input
// R9 - Stop bit 10 slow-down input decelerated to stop
// R10 - Stop bit 12 interpolation error, bit 13 group axis stopped
// R11 - Stop bit 14 pulse buffer overflow, bit 15 interp counter overflow
// R12 - Stop bits 16,17 signal errors, bit 31 axis stop; rest reserved
// R13 - Progress bits 0,1,2 and 4 to 7 motion events
// R14 - Progress bit 11 general, bit 12 trigger comparator match
// R15 - Progress bit 14 counter latch axes 2,3 only; bit 15 origin latch
// R16 - Progress bit 16 slow-down on, bit 19 sync start; 20-31 reserved
// R17 - Host sets factor mask 0x01 for normal stop before enabling
// R18 - Per-card request flag lets host recognise its own request
// R19 - Per-axis type: 0x1 stop word pending, 0x2 progress pending
// R20 - Sources kept separately for each of four axes
// R21 - Status bits hold until word read, then clear; request then drops
// R22 - Request is OR of stop bits and masked progress bits, gated
module mai_axis_int (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  // Event pulses from the motion core, per axis
  input  wire mai_pkg::mai_axis_evt_t [mai_pkg::NUM_AXES-1:0] axisEvt,
  // Interrupt request toward the host
  output logic                      intRequest,
  output mai_pkg::mai_axis_view_t [mai_pkg::NUM_AXES-1:0] axisView
);

  // =====================================================================
  // Declarations
  logic [31:0] stopWord   [mai_pkg::NUM_AXES];
  logic [31:0] progWord   [mai_pkg::NUM_AXES];
  logic [31:0] factorMask [mai_pkg::NUM_AXES];
  logic [mai_pkg::NUM_AXES-1:0] stopPend;
  logic [mai_pkg::NUM_AXES-1:0] progPend;
  logic [mai_pkg::NUM_AXES-1:0] maskedPend;
  logic [mai_pkg::NUM_AXES-1:0] stopRead;
  logic [mai_pkg::NUM_AXES-1:0] progRead;
  logic [mai_pkg::NUM_AXES-1:0] maskWrite;
  logic        interrupt_service_flag;
  logic        addrPhase;
  logic        wrPending;
  logic [7:0]  wrAddr;
  logic [7:0]  rdAddr;
  logic [31:0] next_hrdata;
  logic        next_request;

  // =====================================================================
  // Bus address phase
  assign addrPhase = hsel & hready & (htrans == mai_pkg::HTRANS_NONSEQ);
  assign rdAddr    = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Latch write address for the data phase
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrPending <= 1'b0;
      wrAddr    <= 8'h00;
    end else begin
      wrPending <= addrPhase & hwrite & (haddr[31:8] == 24'h00_0000);
      wrAddr    <= haddr[7:0];
    end
  end

  // =====================================================================
  // Per-axis status words
  genvar ax;
  generate
    for (ax = 0; ax < mai_pkg::NUM_AXES; ax++) begin : g_axis
      localparam logic [7:0] BASE = 8'(ax * 16);
      logic [31:0] stopValid;
      logic [31:0] progValid;

      // R5 soft limits
      // R6 comparator stop
      // R7 limits and alarm
      // R8 external stops
      // R9 slow-down stop
      // R10 interpolation stops
      // R11 overflow stops
      // R12 errors, reserved zero
      assign stopValid = mai_pkg::STOP_VALID_BITS;
      // R15 latch axes 2,3
      // R13 motion events
      // R14 comparator events
      // R16 inputs, reserved zero
      assign progValid = (ax >= 2) ? mai_pkg::PROG_VALID_BITS :
        (mai_pkg::PROG_VALID_BITS &
         ~(32'h0000_0001 << mai_pkg::PROG_CNT_LATCH));

      // Read strobes that clear each word, and the factor mask write strobe
      assign stopRead[ax] = addrPhase & ~hwrite &
        (haddr[31:8] == 24'h00_0000) &
        (rdAddr == BASE + mai_pkg::OFS_STOP_CAUSE);
      assign progRead[ax] = addrPhase & ~hwrite &
        (haddr[31:8] == 24'h00_0000) &
        (rdAddr == BASE + mai_pkg::OFS_MOTION_PROG);
      assign maskWrite[ax] = wrPending &
        (wrAddr == BASE + mai_pkg::OFS_FACTOR_MASK);

      // R2 separate words
      // R20 per-axis sources
      // R21 clear on read, set wins
      always_ff @(posedge clock) begin
        if (!resetn) begin
          stopWord[ax] <= mai_pkg::RST_STATUS;
        end else begin
          stopWord[ax] <= (stopRead[ax] ? 32'h0000_0000 : stopWord[ax])
                        | (axisEvt[ax].stopCause & stopValid);
        end
      end

      // R21 clear on read, set wins
      always_ff @(posedge clock) begin
        if (!resetn) begin
          progWord[ax] <= mai_pkg::RST_STATUS;
        end else begin
          progWord[ax] <= (progRead[ax] ? 32'h0000_0000 : progWord[ax])
                        | (axisEvt[ax].progress & progValid);
        end
      end

      // Factor mask written by software
      always_ff @(posedge clock) begin
        if (!resetn) begin
          factorMask[ax] <= mai_pkg::RST_FACTOR_MASK;
        end else if (maskWrite[ax]) begin
          factorMask[ax] <= hwdata & progValid;
        end
      end

      // R4 stop causes unmasked
      assign stopPend[ax]   = |stopWord[ax];
      assign progPend[ax]   = |progWord[ax];
      // R3 factor mask gate
      assign maskedPend[ax] = |(progWord[ax] & factorMask[ax]);

      // R19 type indicator
      always_ff @(posedge clock) begin
        if (!resetn) begin
          axisView[ax].intType <= 2'h0;
        end else begin
          axisView[ax].intType[mai_pkg::TYPE_STOP_BIT] <= stopPend[ax];
          axisView[ax].intType[mai_pkg::TYPE_PROG_BIT] <= progPend[ax];
        end
      end
    end
  endgenerate

  // =====================================================================
  // Service enable flag
  always_ff @(posedge clock) begin
    if (!resetn) begin
      interrupt_service_flag <= mai_pkg::RST_SVC_FLAG;
    end else if (wrPending && wrAddr == mai_pkg::OFS_SERVICE_CTRL) begin
      interrupt_service_flag <= hwdata[mai_pkg::SVC_FLAG_BIT];
    end
  end

  // =====================================================================
  // Interrupt request
  // R1 service gate
  // R22 OR of all causes
  assign next_request = interrupt_service_flag &
                        (|(stopPend | maskedPend));

  // R18 card request flag
  always_ff @(posedge clock) begin
    if (!resetn) begin
      intRequest <= 1'b0;
    end else begin
      intRequest <= next_request;
    end
  end

  // =====================================================================
  // Read data mux, captured at the address phase
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      if (rdAddr < mai_pkg::AXIS_SPAN) begin
        case (rdAddr[3:0])
          mai_pkg::OFS_STOP_CAUSE[3:0]: begin
            next_hrdata = stopWord[rdAddr[5:4]];
          end
          mai_pkg::OFS_MOTION_PROG[3:0]: begin
            next_hrdata = progWord[rdAddr[5:4]];
          end
          mai_pkg::OFS_FACTOR_MASK[3:0]: begin
            // Bypass a mask write still in its data phase
            if (wrPending && wrAddr == rdAddr) begin
              next_hrdata = hwdata & (rdAddr[5] ? mai_pkg::PROG_VALID_BITS
                : (mai_pkg::PROG_VALID_BITS &
                   ~(32'h0000_0001 << mai_pkg::PROG_CNT_LATCH)));
            end else begin
              next_hrdata = factorMask[rdAddr[5:4]];
            end
          end
          mai_pkg::OFS_INT_TYPE[3:0]: begin
            next_hrdata = {30'h0000_0000, progPend[rdAddr[5:4]],
                           stopPend[rdAddr[5:4]]};
          end
          default: begin
            next_hrdata = 32'h0000_0000;
          end
        endcase
      end else if (rdAddr == mai_pkg::OFS_SERVICE_CTRL) begin
        if (wrPending && wrAddr == rdAddr) begin
          next_hrdata = {31'h0000_0000, hwdata[mai_pkg::SVC_FLAG_BIT]};
        end else begin
          next_hrdata = {31'h0000_0000, interrupt_service_flag};
        end
      end else if (rdAddr == mai_pkg::OFS_CARD_REQ) begin
        // R18 card request readback
        next_hrdata = {31'h0000_0000, intRequest};
      end
    end
  end

  // Read data register, valid during the data phase
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

endmodule : mai_axis_int

// ==== verification/mai_axis_int_props.sv ====
`timescale 1ns/10ps
// =====================================================================
// Checker of the interrupt block ports
module mai_chk (
  // Clock, reset and bus
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Events and interrupt view
  input wire mai_pkg::mai_axis_evt_t [mai_pkg::NUM_AXES-1:0] axisEvt,
  input wire logic        intRequest,
  input wire mai_pkg::mai_axis_view_t [mai_pkg::NUM_AXES-1:0] axisView
);
  logic take;
  logic wrSvc;
  logic svc;
  logic [31:0] pv1;
  // Taken address phase
  assign take = hsel && hready && htrans == mai_pkg::HTRANS_NONSEQ;
  assign pv1 = mai_pkg::PROG_VALID_BITS & 32'hffff_bfff;
  // Write to service flag pending
  always_ff @(posedge clock) begin
    if (!resetn) wrSvc <= 1'b0;
    else wrSvc <= take && hwrite && haddr == 32'h0000_0040;
  end
  // Shadow of the service flag
  always_ff @(posedge clock) begin
    if (!resetn) svc <= 1'b0;
    else if (wrSvc) svc <= hwdata[0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_stop_type;
    |(axisEvt[0].stopCause & mai_pkg::STOP_VALID_BITS) |->
      ##2 axisView[0].intType[0];
  endproperty
  property p_prog_type;
    |(axisEvt[1].progress & pv1) |-> ##2 axisView[1].intType[1];
  endproperty
  property p_rd_clr;
    take && !hwrite && haddr == 32'h0 && axisEvt[0].stopCause == 32'h0
      |-> ##2 !axisView[0].intType[0];
  endproperty
  property p_req_pend;
    intRequest |-> |axisView;
  endproperty
  property p_gate;
    !svc && !$past(svc) |-> !intRequest;
  endproperty
  property p_stop_req;
    svc && |(axisEvt[0].stopCause & mai_pkg::STOP_VALID_BITS) |->
      ##2 intRequest;
  endproperty
  property p_hold;
    !(take && !hwrite) |=> $stable(hrdata);
  endproperty
  property p_rst;
    disable iff (1'b0)
    !resetn |=> !intRequest && axisView == '0 && hrdata == 32'h0;
  endproperty
  a_stop_type: assert property (p_stop_type) else $error("stop type");
  a_prog_type: assert property (p_prog_type) else $error("prog type");
  a_rd_clr: assert property (p_rd_clr) else $error("no clear");
  a_req_pend: assert property (p_req_pend) else $error("no cause");
  a_gate: assert property (p_gate) else $error("request ungated");
  a_stop_req: assert property (p_stop_req) else $error("no request");
  a_hold: assert property (p_hold) else $error("hrdata moved");
  a_rst: assert property (p_rst) else $error("reset state");
  c_req: cover property (intRequest);
  c_svc: cover property (svc);
  c_rd: cover property (take && !hwrite && haddr == 32'h0);
endmodule : mai_chk

bind mai_axis_int mai_chk i_chk (.clock(clock), .resetn(resetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hresp(hresp),
  .hreadyout(hreadyout), .hrdata(hrdata), .axisEvt(axisEvt),
  .intRequest(intRequest), .axisView(axisView));

// ==== verification/mai_host.sv ====
`timescale 1ns/10ps
// =====================================================================
// Host side bus master
module mai_host (
  // Clock and bus answer
  input  wire logic        clock,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Bus request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // Idle bus at start
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // One single word transfer, data lines scrambled when unused
  task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= mai_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clock); while (!hready);
    r = hrdata;
  endtask : xfer
endmodule : mai_host

// ==== verification/mai_axis_int_tb.sv ====
`timescale 1ns/10ps
// =====================================================================
// Self-checking bench of the interrupt block
module mai_axis_int_tb;
  logic        clock, resetn, hsel, hwrite, hreadyout, hresp, intRequest;
  logic [31:0] haddr, hwdata, hrdata, lfsr, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  mai_pkg::mai_axis_evt_t [mai_pkg::NUM_AXES-1:0]  axisEvt;
  mai_pkg::mai_axis_view_t [mai_pkg::NUM_AXES-1:0] axisView;
  logic [31:0] stopW[4], progW[4], maskW[4];
  logic        svc;
  int          errors, checked, a;
  mai_axis_int i_dut (.clock(clock), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .axisEvt(axisEvt),
    .intRequest(intRequest), .axisView(axisView));
  mai_host i_host (.clock(clock), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  // Clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++)
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic logic [31:0] pv(int x);
    return mai_pkg::PROG_VALID_BITS & (x < 2 ? 32'hffff_bfff : 32'hffff_ffff);
  endfunction : pv
  function automatic logic expReq();
    logic r;
    r = 1'b0;
    for (int x = 0; x < 4; x++) r |= (|stopW[x]) | (|(progW[x] & maskW[x]));
    return r & svc;
  endfunction : expReq
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [31:0] ad, exp);
    i_host.xfer(1'b0, ad, 32'h0, rd);
    #1;
    chk(rd, exp);
  endtask : rdc
  task automatic wr(input logic [31:0] ad, d);
    i_host.xfer(1'b1, ad, d, rd);
  endtask : wr
  task automatic chkView();
    for (int x = 0; x < 4; x++)
      chk(32'(axisView[x].intType), {30'h0, |progW[x], |stopW[x]});
    chk({30'h0, hreadyout, hresp}, 32'h2);
    chk(32'(intRequest), 32'(expReq()));
    rdc(32'h44, 32'(expReq()));
  endtask : chkView
  task automatic pulse(int x, logic [31:0] s, p);
    @(posedge clock);
    axisEvt[x] <= {s, p};
    @(posedge clock);
    axisEvt[x] <= '0;
    stopW[x] |= s & mai_pkg::STOP_VALID_BITS;
    progW[x] |= p & pv(x);
    repeat (2) @(posedge clock);
    #1;
  endtask : pulse
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("watchdog expired");
    complete_run();
  end
  // Main sequence
  initial begin
    axisEvt = '0;
    resetn = 1'b0;
    lfsr = 32'd91;
    errors = 0;
    checked = 0;
    svc = 1'b0;
    for (int x = 0; x < 4; x++) {stopW[x], progW[x], maskW[x]} = '0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int o = 0; o < 72; o += 4) rdc(o, 32'h0);
    wr(32'h100, 32'hffff_ffff);
    rdc(32'h100, 32'h0);
    $display("test reset done");
    for (int n = 0; n < 24; n++) begin
      a = n % 4;
      maskW[a] = n == 0 ? 32'h1 : rnd() & pv(0);
      wr(a * 16 + 8, maskW[a] | ~mai_pkg::PROG_VALID_BITS);
      rdc(a * 16 + 8, maskW[a]);
      if (n == 4 || n == 16) begin
        svc = n == 4;
        wr(32'h40, rnd() & 32'hffff_fffe | 32'(svc));
        rdc(32'h40, 32'(svc));
      end
      pulse(a, n[3] ? 32'h0 : rnd(), rnd());
      chkView();
      if (n[2]) begin
        rdc(a * 16, stopW[a]);
        stopW[a] = 32'h0;
      end
      if (n[0]) begin
        rdc(a * 16 + 4, progW[a]);
        progW[a] = 32'h0;
      end
      chkView();
    end
    $display("test events done");
    for (int x = 0; x < 4; x++) begin
      rdc(x * 16, stopW[x]);
      rdc(x * 16 + 4, progW[x]);
      {stopW[x], progW[x]} = '0;
    end
    chkView();
    $display("test drain done");
    // reset in mid-run clears flag, masks and words
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    svc = 1'b0;
    for (int x = 0; x < 4; x++) {stopW[x], progW[x], maskW[x]} = '0;
    for (int x = 0; x < 4; x++) rdc(x * 16 + 8, 32'h0);
    rdc(32'h40, 32'h0);
    chkView();
    $display("test second reset done");
    complete_run();
  end
endmodule : mai_axis_int_tb
